// *** hw/hv_lock_pkg.sv ***
package hv_lock_pkg;

    // ------------------------------------------------------------
    // command byte layout
    // ------------------------------------------------------------
    localparam int CMD_BITS = 8;
    localparam int ADDR_MSB = 7;
    localparam int ADDR_LSB = 4;
    localparam int OP_MSB = 3;
    localparam int OP_LSB = 2;
    localparam logic [2:0] ERR_DECIDE_COUNT = 3'h5;
    localparam logic [2:0] LAST_BIT_COUNT = 3'h7;

    // ------------------------------------------------------------
    // memory map
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_WIPER0 = 4'h0;
    localparam logic [3:0] ADDR_WIPER1 = 4'h1;
    localparam logic [3:0] ADDR_LOCK0 = 4'h2;
    localparam logic [3:0] ADDR_LOCK1 = 4'h3;
    localparam logic [3:0] ADDR_TERMINAL = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h5;
    localparam logic [3:0] ADDR_PROTECT = 4'hF;

    // ------------------------------------------------------------
    // reset values and wiper range
    // ------------------------------------------------------------
    localparam int WIPER_W = 9;
    localparam logic [8:0] WIPER_FULL_SCALE = 9'h100;
    localparam logic [8:0] WIPER_RESET = 9'h080;
    localparam logic LOCK_RESET = 1'b0;
    localparam logic PROTECT_RESET = 1'b0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int NV_WRITE_TIME_NS = 5_000_000;
    localparam int NV_WRITE_CYCLES = (NV_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        OP_WRITE = 2'b00,
        OP_INC = 2'b01,
        OP_DEC = 2'b10,
        OP_READ = 2'b11
    } cmd_op_t;

    typedef enum logic {
        NV_IDLE = 1'b0,
        NV_BUSY = 1'b1
    } nv_state_t;

    function automatic logic is_volatile(input logic [3:0] addr);
        is_volatile = (addr == ADDR_WIPER0) || (addr == ADDR_WIPER1) ||
                      (addr == ADDR_TERMINAL) || (addr == ADDR_STATUS);
    endfunction

    function automatic logic is_lock_addr(input logic [3:0] addr);
        is_lock_addr = (addr == ADDR_LOCK0) || (addr == ADDR_LOCK1) || (addr == ADDR_PROTECT);
    endfunction

    // increment or decrement that names no usable target
    function automatic logic cmd_invalid(input logic [3:0] addr, input logic [1:0] op,
                                         input logic hv);
        logic incdec;
        incdec = (op == OP_INC) || (op == OP_DEC);
        cmd_invalid = incdec && (addr != ADDR_WIPER0) && (addr != ADDR_WIPER1) &&
                      !(hv && is_lock_addr(addr));
    endfunction

endpackage

// *** hw/sync2.sv ***
module sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_q;

    // ------------------------------------------------------------
    // two-flop crossing
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            stage1_q <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1_q <= async_in;
            sync_out <= stage1_q;
        end
    end

endmodule // sync2

// *** hw/hv_lock_protect_command.sv ***
// Functional notes
// - nv write starts after byte and select release
// - select may reassert at once after release
// - during write only volatile addresses accepted
// - write-active flag shows write in progress
// - high-voltage inc/dec on wiper increments it
// - high-voltage inc/dec on terminal sets error
// - dec enables, inc disables lock or protect
// - inc/dec to reserved addresses is invalid
// - high-voltage inc/dec on 02h/03h/0Fh modifies bits
// - error pulls serial out low until release
module hv_lock_protect_command #(
    parameter int unsigned WRITE_CYCLES = hv_lock_pkg::NV_WRITE_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic high_voltage_select_level,
    output logic sdo_out,
    output logic sdo_oe,
    output logic [hv_lock_pkg::WIPER_W-1:0] wiper0_q,
    output logic [hv_lock_pkg::WIPER_W-1:0] wiper1_q,
    output logic wiper0_lock_bit,
    output logic wiper1_lock_bit,
    output logic write_protect_bit,
    output logic write_cycle_active_flag,
    output logic command_error_flag,
    output logic pass_strobe,
    output logic [hv_lock_pkg::CMD_BITS-1:0] pass_byte,
    output logic pass_hv
);
    import hv_lock_pkg::*;

    // ------------------------------------------------------------
    // link domain: shift in command bytes on sck
    // ------------------------------------------------------------
    logic link_rst;
    logic [2:0] bit_cnt_q;
    logic [CMD_BITS-2:0] shift_q;
    logic hv_s1_q;
    logic hv_s2_q;
    logic skip_q;
    logic link_err_q;
    logic [CMD_BITS-1:0] byte_q;
    logic byte_hv_q;
    logic byte_tog_q;
    logic [CMD_BITS-1:0] byte_now;
    logic [5:0] head_now;

    // frame logic is cleared by the select itself, so nothing waits on sck
    assign link_rst = reset | cs_n;
    assign byte_now = {shift_q, sdi};
    assign head_now = {shift_q[4:0], sdi};

    always_ff @(posedge sck or posedge link_rst)
    begin
        if (link_rst)
        begin
            bit_cnt_q <= 3'h0;
            shift_q <= '0;
        end
        else
        begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            shift_q <= byte_now[CMD_BITS-2:0];
        end
    end

    // qualifier from the raised select level
    always_ff @(posedge sck or posedge link_rst)
    begin
        if (link_rst)
        begin
            hv_s1_q <= 1'b0;
            hv_s2_q <= 1'b0;
        end
        else
        begin
            hv_s1_q <= high_voltage_select_level;
            hv_s2_q <= hv_s1_q;
        end
    end

    // error decided once address and opcode are in
    always_ff @(posedge sck or posedge link_rst)
    begin
        if (link_rst)
        begin
            link_err_q <= 1'b0;
        end
        else if (bit_cnt_q == ERR_DECIDE_COUNT && !skip_q &&
                 cmd_invalid(head_now[5:2], head_now[1:0], hv_s2_q))
        begin
            link_err_q <= 1'b1;
        end
    end

    // open-drain serial out, pulled low after an error
    assign sdo_out = 1'b0;
    assign sdo_oe = link_err_q;

    // second byte of a two-byte command is not ours
    always_ff @(posedge sck or posedge link_rst)
    begin
        if (link_rst)
        begin
            skip_q <= 1'b0;
        end
        else if (bit_cnt_q == LAST_BIT_COUNT)
        begin
            if (skip_q)
            begin
                skip_q <= 1'b0;
            end
            else
            begin
                skip_q <= (byte_now[OP_MSB:OP_LSB] == OP_WRITE) ||
                          (byte_now[OP_MSB:OP_LSB] == OP_READ);
            end
        end
    end

    // full byte handed over by toggle; held stable for the next eight clocks
    always_ff @(posedge sck or posedge reset)
    begin
        if (reset)
        begin
            byte_q <= '0;
            byte_hv_q <= 1'b0;
            byte_tog_q <= 1'b0;
        end
        else if (!cs_n && bit_cnt_q == LAST_BIT_COUNT && !skip_q)
        begin
            byte_q <= byte_now;
            byte_hv_q <= hv_s2_q;
            byte_tog_q <= ~byte_tog_q;
        end
    end

    // ------------------------------------------------------------
    // crossing into the system clock
    // ------------------------------------------------------------
    logic [1:0] sync_out;
    logic tog_sync;
    logic cs_sync;
    logic tog_seen_q;
    logic cs_seen_q;
    logic byte_evt;
    logic cs_rise;

    sync2 #(
        .WIDTH(2)
    ) u_sync (
        .clk(clk),
        .reset(reset),
        .async_in({byte_tog_q, ~cs_n}),
        .sync_out(sync_out)
    );

    assign tog_sync = sync_out[1];
    // select crosses as active high so the flop reset level matches idle
    assign cs_sync = ~sync_out[0];

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            tog_seen_q <= 1'b0;
            cs_seen_q <= 1'b1;
        end
        else
        begin
            tog_seen_q <= tog_sync;
            cs_seen_q <= cs_sync;
        end
    end

    assign byte_evt = tog_sync ^ tog_seen_q;
    assign cs_rise = cs_sync & ~cs_seen_q;

    // ------------------------------------------------------------
    // command decode in the system clock
    // ------------------------------------------------------------
    nv_state_t state_q;
    logic [3:0] cmd_addr;
    logic [1:0] cmd_op;
    logic cmd_bad;
    logic blocked;
    logic frame_err_q;
    logic accept;
    logic nv_cmd;
    logic pend_q;
    logic [3:0] pend_addr_q;
    logic [1:0] pend_op_q;
    logic start_write;
    logic [3:0] start_addr;
    logic [1:0] start_op;
    logic [31:0] wait_cnt_q;
    logic write_done;

    assign cmd_addr = byte_q[ADDR_MSB:ADDR_LSB];
    assign cmd_op = byte_q[OP_MSB:OP_LSB];
    assign cmd_bad = cmd_invalid(cmd_addr, cmd_op, byte_hv_q);
    assign blocked = (state_q == NV_BUSY) && !is_volatile(cmd_addr);
    assign accept = byte_evt && !blocked && !frame_err_q;
    assign nv_cmd = accept && byte_hv_q && is_lock_addr(cmd_addr) &&
                    (cmd_op == OP_INC || cmd_op == OP_DEC);

    // error flag held for the rest of the frame
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            frame_err_q <= 1'b0;
        end
        else if (accept && cmd_bad)
        begin
            frame_err_q <= 1'b1;
        end
        else if (cs_rise)
        begin
            frame_err_q <= 1'b0;
        end
    end

    assign command_error_flag = frame_err_q;

    // ------------------------------------------------------------
    // volatile wipers
    // ------------------------------------------------------------
    function automatic logic [WIPER_W-1:0] step_up(input logic [WIPER_W-1:0] w);
        step_up = (w < WIPER_FULL_SCALE) ? w + 9'h001 : w;
    endfunction

    function automatic logic [WIPER_W-1:0] step_down(input logic [WIPER_W-1:0] w);
        step_down = (w != 9'h000 && w <= WIPER_FULL_SCALE) ? w - 9'h001 : w;
    endfunction

    function automatic logic [WIPER_W-1:0] wiper_next(input logic [WIPER_W-1:0] w,
                                                      input logic [1:0] op, input logic hv);
        if (hv && (op == OP_INC || op == OP_DEC))
        begin
            wiper_next = step_up(w);
        end
        else if (op == OP_INC)
        begin
            wiper_next = step_up(w);
        end
        else if (op == OP_DEC)
        begin
            wiper_next = step_down(w);
        end
        else
        begin
            wiper_next = w;
        end
    endfunction

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            wiper0_q <= WIPER_RESET;
        end
        else if (accept && cmd_addr == ADDR_WIPER0)
        begin
            wiper0_q <= wiper_next(wiper0_q, cmd_op, byte_hv_q);
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            wiper1_q <= WIPER_RESET;
        end
        else if (accept && cmd_addr == ADDR_WIPER1)
        begin
            wiper1_q <= wiper_next(wiper1_q, cmd_op, byte_hv_q);
        end
    end

    // ------------------------------------------------------------
    // other accepted commands handed onward
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pass_strobe <= 1'b0;
            pass_byte <= '0;
            pass_hv <= 1'b0;
        end
        else
        begin
            pass_strobe <= accept && !cmd_bad && (cmd_op == OP_WRITE || cmd_op == OP_READ);
            if (accept)
            begin
                pass_byte <= byte_q;
                pass_hv <= byte_hv_q;
            end
        end
    end

    // ------------------------------------------------------------
    // pending lock or protect change, waits for select release
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pend_q <= 1'b0;
            pend_addr_q <= 4'h0;
            pend_op_q <= 2'b00;
        end
        else if (cs_rise)
        begin
            pend_q <= 1'b0;
        end
        else if (nv_cmd)
        begin
            pend_q <= 1'b1;
            pend_addr_q <= cmd_addr;
            pend_op_q <= cmd_op;
        end
    end

    // a byte arriving with the release still counts
    assign start_write = cs_rise && (pend_q || nv_cmd);
    assign start_addr = nv_cmd ? cmd_addr : pend_addr_q;
    assign start_op = nv_cmd ? cmd_op : pend_op_q;

    // ------------------------------------------------------------
    // non-volatile bits
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            wiper0_lock_bit <= LOCK_RESET;
            wiper1_lock_bit <= LOCK_RESET;
            write_protect_bit <= PROTECT_RESET;
        end
        else if (start_write)
        begin
            if (start_addr == ADDR_LOCK0)
            begin
                wiper0_lock_bit <= (start_op == OP_DEC);
            end
            if (start_addr == ADDR_LOCK1)
            begin
                wiper1_lock_bit <= (start_op == OP_DEC);
            end
            if (start_addr == ADDR_PROTECT)
            begin
                write_protect_bit <= (start_op == OP_DEC);
            end
        end
    end

    // ------------------------------------------------------------
    // write cycle timer
    // ------------------------------------------------------------
    assign write_done = (wait_cnt_q == WRITE_CYCLES - 32'd1);

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_q <= NV_IDLE;
        end
        else
        begin
            case (state_q)
                NV_IDLE:
                begin
                    if (start_write)
                    begin
                        state_q <= NV_BUSY;
                    end
                end
                NV_BUSY:
                begin
                    if (write_done)
                    begin
                        state_q <= NV_IDLE;
                    end
                end
                default:
                begin
                    state_q <= NV_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            wait_cnt_q <= 32'd0;
        end
        else if (state_q == NV_BUSY && !write_done)
        begin
            wait_cnt_q <= wait_cnt_q + 32'd1;
        end
        else
        begin
            wait_cnt_q <= 32'd0;
        end
    end

    assign write_cycle_active_flag = (state_q == NV_BUSY);

endmodule // hv_lock_protect_command

// *** tb/hv_lock_checker_props.sv ***
module hv_lock_checker
    import hv_lock_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = 20
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic cs_n,
    input wire logic sdo_out,
    input wire logic sdo_oe,
    input wire logic [hv_lock_pkg::WIPER_W-1:0] wiper0_q,
    input wire logic [hv_lock_pkg::WIPER_W-1:0] wiper1_q,
    input wire logic wiper0_lock_bit,
    input wire logic wiper1_lock_bit,
    input wire logic write_protect_bit,
    input wire logic write_cycle_active_flag,
    input wire logic command_error_flag
);
    import hv_lock_pkg::*;

    // ------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------
    logic [2:0] nv_bits;
    int unsigned busy_cnt_q;
    assign nv_bits = {wiper0_lock_bit, wiper1_lock_bit, write_protect_bit};

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            busy_cnt_q <= 0;
        else
            busy_cnt_q <= write_cycle_active_flag ? busy_cnt_q + 1 : 0;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    nv_start_a: assert property (!$stable(nv_bits) |-> $rose(write_cycle_active_flag))
        else $error("nonvolatile bits changed without a write cycle");
    busy_time_a: assert property ($fell(write_cycle_active_flag) |-> busy_cnt_q == WRITE_CYCLES)
        else $error("write cycle length wrong");
    busy_hold_a: assert property (write_cycle_active_flag && $past(write_cycle_active_flag)
        |-> $stable(nv_bits))
        else $error("nonvolatile bits changed during write cycle");
    wiper_step_a: assert property (!$stable(wiper0_q) |-> (wiper0_q - $past(wiper0_q) == 9'h001)
        || ($past(wiper0_q) - wiper0_q == 9'h001))
        else $error("wiper 0 moved by more than one step");
    wiper_range_a: assert property (wiper0_q <= WIPER_FULL_SCALE && wiper1_q <= WIPER_FULL_SCALE)
        else $error("wiper above full scale");
    err_no_move_a: assert property (command_error_flag |-> $stable({wiper0_q, wiper1_q}))
        else $error("wiper moved on a bad command");
    err_clear_a: assert property (cs_n [*5] |-> !command_error_flag)
        else $error("error flag held after release");
    oe_release_a: assert property (cs_n |-> !sdo_oe)
        else $error("serial out pulled while deselected");
    err_drive_a: assert property (command_error_flag && !cs_n |-> sdo_oe)
        else $error("serial out not pulled during error");
endmodule // hv_lock_checker

bind hv_lock_protect_command hv_lock_checker #(.WRITE_CYCLES(WRITE_CYCLES)) u_checker (
    .clk(clk), .reset(reset), .cs_n(cs_n), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
    .wiper0_q(wiper0_q), .wiper1_q(wiper1_q), .wiper0_lock_bit(wiper0_lock_bit),
    .wiper1_lock_bit(wiper1_lock_bit), .write_protect_bit(write_protect_bit),
    .write_cycle_active_flag(write_cycle_active_flag), .command_error_flag(command_error_flag)
);

// *** tb/host_spi_model.sv ***
module host_spi_model (
    input wire logic clk,
    output logic sck,
    output logic cs_n,
    output logic sdi,
    output logic hv
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // idle: clock still, data at pull-up level
    // ------------------------------------------------------------
    initial
    begin
        sck = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b1;
        hv = 1'b0;
    end

    task automatic open(input logic h);
        @(posedge clk);
        #2;
        hv = h;
        cs_n = 1'b0;
    endtask

    task automatic shift(input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
        begin
            sdi = b[i];
            #16;
            sck = 1'b1;
            #16;
            sck = 1'b0;
        end
    endtask

    task automatic close();
        @(posedge clk);
        #2;
        cs_n = 1'b1;
        hv = 1'b0;
        sdi = 1'b1;
        repeat (3) @(posedge clk);
        #2;
    endtask
endmodule // host_spi_model

// *** tb/test_hv_lock_protect_command.sv ***
module test_hv_lock_protect_command;
    timeunit 1ns;
    timeprecision 1ps;
    import hv_lock_pkg::*;

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic sck, cs_n, sdi, hv, sdo_out, sdo_oe, l0, l1, wp, busy, err;
    logic [WIPER_W-1:0] w0, w1;
    logic ps, ph;
    logic [CMD_BITS-1:0] pb;
    int n_pass = 0;
    int n_fail = 0;
    int compares = 0;

    always #12.5 clk = ~clk;

    always @(posedge clk)
        if (ps === 1'b1)
            n_pass++;

    host_spi_model u_host (.clk(clk), .sck(sck), .cs_n(cs_n), .sdi(sdi), .hv(hv));

    hv_lock_protect_command #(.WRITE_CYCLES(40)) u_dut (
        .clk(clk), .reset(reset), .sck(sck), .cs_n(cs_n), .sdi(sdi),
        .high_voltage_select_level(hv), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
        .wiper0_q(w0), .wiper1_q(w1), .wiper0_lock_bit(l0), .wiper1_lock_bit(l1),
        .write_protect_bit(wp), .write_cycle_active_flag(busy), .command_error_flag(err),
        .pass_strobe(ps), .pass_byte(pb), .pass_hv(ph)
    );

    task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic frame(input logic [7:0] b, input logic h);
        u_host.open(h);
        u_host.shift(b);
        u_host.close();
    endtask

    task automatic wait_clear();
        for (int i = 0; i < 100 && busy !== 1'b0; i++)
            cyc(1);
        chk("write flag end", 9'h000, busy);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk("wiper0", 9'h080, w0);
        chk("wiper1", 9'h080, w1);
        chk("nv bits", 9'h000, {l0, l1, wp});
        chk("flags", 9'h000, {busy, err, sdo_oe});
    endtask

    task automatic t_lock_write();
        u_host.open(1'b1);
        u_host.shift(8'h28);
        cyc(6);
        chk("lock0 before release", 9'h000, l0);
        u_host.close();
        u_host.open(1'b1);
        u_host.shift(8'h38);
        u_host.shift(8'h04);
        u_host.close();
        cyc(3);
        chk("lock0", 9'h001, l0);
        chk("write flag", 9'h001, busy);
        chk("lock1 during write", 9'h000, l1);
        chk("wiper0 during write", 9'h081, w0);
        wait_clear();
        frame(8'h38, 1'b1);
        cyc(3);
        chk("lock1 after write", 9'h001, l1);
        wait_clear();
    endtask

    task automatic t_codes();
        logic [7:0] cmd [4] = '{8'hF8, 8'hF4, 8'h24, 8'h34};
        logic [2:0] exp [4] = '{3'h7, 3'h6, 3'h2, 3'h0};
        for (int i = 0; i < 4; i++)
        begin
            frame(cmd[i], 1'b1);
            cyc(3);
            chk("nv bits", {6'h00, exp[i]}, {l0, l1, wp});
            wait_clear();
        end
        frame(8'h18, 1'b1);
        cyc(3);
        chk("wiper1", 9'h081, w1);
    endtask

    task automatic bad(input logic [7:0] b, input logic h);
        u_host.open(h);
        u_host.shift(b);
        cyc(5);
        chk("error flag", 9'h001, err);
        chk("sdo pull", 9'h001, sdo_oe);
        u_host.shift(8'h04);
        chk("sdo pull later", 9'h001, sdo_oe);
        chk("sdo value", 9'h000, sdo_out);
        u_host.close();
        chk("sdo released", 9'h000, sdo_oe);
        cyc(3);
        chk("error cleared", 9'h000, err);
        chk("wiper0 kept", 9'h081, w0);
        chk("nv bits kept", 9'h000, {l0, l1, wp});
    endtask

    task automatic t_errors();
        for (int a = 4; a <= 14; a++)
            bad({a[3:0], (a[0] ? 2'b01 : 2'b10), 2'b00}, 1'b1);
        bad(8'h28, 1'b0);
    endtask

    task automatic t_mid_reset();
        frame(8'h28, 1'b1);
        chk("lock0 set", 9'h001, l0);
        chk("write flag set", 9'h001, busy);
        reset = 1'b1;
        cyc(2);
        reset = 1'b0;
        cyc(3);
        t_reset();
    endtask

    task automatic t_pass();
        int seen;
        seen = n_pass;
        u_host.open(1'b0);
        u_host.shift(8'h08);
        u_host.shift(8'h0C);
        u_host.shift(8'h55);
        cyc(5);
        chk("data byte skipped", 9'h000, {err, sdo_oe});
        u_host.close();
        chk("wiper0 normal dec", 9'h07F, w0);
        chk("pass count", 9'h001, 9'(n_pass - seen));
        chk("pass byte", 9'h00C, {1'b0, pb});
        chk("pass hv", 9'h000, ph);
    endtask

    task automatic end_of_test();
        if (n_fail == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (8) @(posedge clk);
        #2;
        reset = 1'b0;
        cyc(3);
        t_reset();
        t_lock_write();
        t_codes();
        t_errors();
        t_mid_reset();
        t_pass();
        end_of_test();
    end

    initial
    begin
        #200_000;
        n_fail++;
        end_of_test();
    end
endmodule // test_hv_lock_protect_command
